// >>> rtl/pin_mode_pkg.sv
// Constants and types shared by the operating-mode pin function selector
package pin_mode_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] MODE_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] SYSTEM_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] PIN_FUNCTION_ADDR = 8'h08;
  localparam logic [7:0] PORT_DIRECTION_ADDR = 8'h0c;
  localparam logic [7:0] BUS_STATUS_ADDR = 8'h10;
  // Field positions
  localparam int RAM_ENABLE_BIT = 0;
  localparam int MODE_FIXED_ONE_BIT = 7;
  localparam int STATUS_BUS16_BIT = 4;
  localparam int STATUS_ROM_BIT = 5;
  localparam int STATUS_EXT_BIT = 6;
  localparam int STATUS_RAM_EXT_BIT = 7;
  localparam int STATUS_VALID_BIT = 8;
  // Address line numbers on the pin vector
  localparam int PORT_C_TOP_LINE = 7;
  localparam int MODE5_FIXED_TOP_LINE = 20;
  localparam int FIRST_AE_LINE = 8;
  localparam int LINE_COUNT = 24;
  // Values after reset
  localparam logic RAM_ENABLE_RESET = 1'b1;
  localparam logic [3:0] ADDRESS_ENABLE_RESET = 4'h0;
  localparam logic [23:0] DIRECTION_RESET = 24'h000000;
  localparam logic [2:0] MODE_STATUS_RESET = 3'h0;
  // Cycles for the mode pins to pass the synchroniser after reset
  localparam logic [1:0] MODE_SETTLE_CYCLES = 2'h2;
  // Mode pin codes
  localparam logic [2:0] MODE4_CODE = 3'h4;
  localparam logic [2:0] MODE5_CODE = 3'h5;
  localparam logic [2:0] MODE6_CODE = 3'h6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_4 = 4'h1,
    MODE_5 = 4'h2,
    MODE_6 = 4'h4,
    MODE_7 = 4'h8
  } op_mode_t;
endpackage : pin_mode_pkg

// >>> rtl/pin_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second; it may be metastable
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign pin_out = stage2_reg;
endmodule : pin_sync

// >>> rtl/pin_mode_select.sv
// Operating-mode pin function selector with AXI4-Lite registers
`timescale 1ns/1ps
// Functional notes
// - Mode 5: ROM off, address, data, control buses
// - Mode 5 reset: P13-P11 inputs, A20-A8 driven
// - Mode 5: A23-A21 gated by address-enable field
// - Disabled address pin with direction 1 is output
// - Mode 5: port C always drives A7-A0
// - Modes 5,6: 8-bit bus, 16 if any area
// - Mode 6: ROM on, address ports input after reset
// - Mode 6: A23-A8 gated by address-enable field
// - Mode 6: port C address only when direction 1
// - Mode 6: ports D, E data, port F control
// - Mode 7: ROM on, external access blocked
// - Mode 7: every pin general input/output
// - ROM-less part: RAM disable routes region external
// - Mode pins latched into status on read
// - Mode 4: bus starts 16 bits wide
module pin_mode_select
  import pin_mode_pkg::*;
#(
  parameter bit ROM_LESS = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] mode_select_pins,
  input wire logic [7:0] area_16bit,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [23:0] addr_out_en,
  output logic [23:0] port_out_en,
  output logic data_low_en,
  output logic data_high_en,
  output logic bus_ctrl_en,
  output logic rom_enable,
  output logic external_access_en,
  output logic ram_external_route
);
  typedef struct packed {
    logic [1:0] settle_cnt;
    logic mode_ok;
    op_mode_t mode;
    logic [2:0] mode_status;
    logic onchip_ram_enable;
    logic [3:0] address_enable_field;
    logic [23:0] direction;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [23:0] addr_out_en;
    logic [23:0] port_out_en;
    logic data_low_en;
    logic data_high_en;
    logic bus_ctrl_en;
    logic rom_enable;
    logic external_access_en;
    logic ram_external_route;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [2:0] mode_pins_sync;
  logic [23:0] line_addr;
  logic [23:0] line_port;
  logic bus_16;
  logic wr_go;
  logic [31:0] read_word;
  logic read_ok;

  pin_sync #(.WIDTH(3)) mode_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(mode_select_pins),
    .pin_out(mode_pins_sync)
  );

  // Until the mode is known every pin stays an input
  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++) begin : g_line
      logic ae_on;
      logic fixed_on;
      assign ae_on = (state_reg.address_enable_field != 4'h0) &&
        (gi <= FIRST_AE_LINE + int'(state_reg.address_enable_field));
      assign fixed_on = (gi <= MODE5_FIXED_TOP_LINE);
      always_comb begin
        line_addr[gi] = 1'b0;
        if (state_reg.mode_ok) begin
          unique case (state_reg.mode)
            MODE_4, MODE_5: begin
              if (gi <= PORT_C_TOP_LINE)
                line_addr[gi] = 1'b1;
              else if (fixed_on)
                line_addr[gi] = 1'b1;
              else
                line_addr[gi] = ae_on;
            end
            MODE_6: begin
              if (gi <= PORT_C_TOP_LINE)
                line_addr[gi] = state_reg.direction[gi];
              else
                line_addr[gi] = ae_on;
            end
            MODE_7: line_addr[gi] = 1'b0;
          endcase
        end
      end
      // Port C has no port output role outside single-chip mode
      assign line_port[gi] = state_reg.mode_ok &&
        state_reg.direction[gi] && !line_addr[gi] &&
        !(gi <= PORT_C_TOP_LINE && state_reg.mode != MODE_7);
    end
  endgenerate

  // Mode 4 width follows the bus controller's 16-bit areas too
  assign bus_16 = |area_16bit;

  assign wr_go = state_reg.aw_have && state_reg.w_have &&
    !state_reg.bvalid;

  always_comb begin
    read_word = 32'h00000000;
    read_ok = 1'b1;
    unique case (s_axi_araddr)
      MODE_CONTROL_ADDR: begin
        read_word[MODE_FIXED_ONE_BIT] = 1'b1;
        read_word[2:0] = mode_pins_sync;
      end
      SYSTEM_CONTROL_ADDR:
        read_word[RAM_ENABLE_BIT] = state_reg.onchip_ram_enable;
      PIN_FUNCTION_ADDR:
        read_word[3:0] = state_reg.address_enable_field;
      PORT_DIRECTION_ADDR: read_word[23:0] = state_reg.direction;
      BUS_STATUS_ADDR: begin
        read_word[3:0] = state_reg.mode;
        read_word[STATUS_BUS16_BIT] = state_reg.data_high_en;
        read_word[STATUS_ROM_BIT] = state_reg.rom_enable;
        read_word[STATUS_EXT_BIT] = state_reg.external_access_en;
        read_word[STATUS_RAM_EXT_BIT] = state_reg.ram_external_route;
        read_word[STATUS_VALID_BIT] = state_reg.mode_ok;
      end
      default: read_ok = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    // Mode is taken once, after the pins have crossed the synchroniser
    if (!state_reg.mode_ok) begin
      if (state_reg.settle_cnt == MODE_SETTLE_CYCLES) begin
        state_next.mode_ok = 1'b1;
        unique case (mode_pins_sync)
          MODE4_CODE: state_next.mode = MODE_4;
          MODE5_CODE: state_next.mode = MODE_5;
          MODE6_CODE: state_next.mode = MODE_6;
          default: state_next.mode = MODE_7;
        endcase
      end else begin
        state_next.settle_cnt = state_reg.settle_cnt + 2'h1;
      end
    end

    // Write channels are taken in either order
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;
    if (wr_go) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      unique case (state_reg.aw_addr)
        MODE_CONTROL_ADDR, BUS_STATUS_ADDR: ;
        SYSTEM_CONTROL_ADDR:
          if (state_reg.w_strb[0])
            state_next.onchip_ram_enable =
              state_reg.w_data[RAM_ENABLE_BIT];
        PIN_FUNCTION_ADDR:
          if (state_reg.w_strb[0])
            state_next.address_enable_field = state_reg.w_data[3:0];
        PORT_DIRECTION_ADDR:
          for (int b = 0; b < 3; b++) begin
            if (state_reg.w_strb[b])
              state_next.direction[b*8 +: 8] =
                state_reg.w_data[b*8 +: 8];
          end
        default: state_next.bresp = RESP_SLVERR;
      endcase
    end
    state_next.awready = !state_next.aw_have && !state_next.bvalid;
    state_next.wready = !state_next.w_have && !state_next.bvalid;

    // Read answers one cycle after the address is taken
    if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_word;
      state_next.rresp = read_ok ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == MODE_CONTROL_ADDR)
        state_next.mode_status = mode_pins_sync;
    end
    state_next.arready = !state_next.rvalid;

    // Pin roles follow the held mode one cycle later
    state_next.addr_out_en = line_addr;
    state_next.port_out_en = line_port;
    state_next.data_low_en = state_reg.mode_ok &&
      state_reg.mode != MODE_7;
    state_next.bus_ctrl_en = state_reg.mode_ok &&
      state_reg.mode != MODE_7;
    state_next.data_high_en = state_reg.mode_ok &&
      state_reg.mode != MODE_7 && bus_16;
    state_next.rom_enable = state_reg.mode_ok &&
      (state_reg.mode == MODE_6 ||
       state_reg.mode == MODE_7);
    state_next.external_access_en = state_reg.mode_ok &&
      state_reg.mode != MODE_7;
    // A ROM-less part sends the RAM region outside when RAM is off
    state_next.ram_external_route = ROM_LESS &&
      !state_reg.onchip_ram_enable &&
      state_reg.mode_ok && state_reg.mode != MODE_7;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.mode <= MODE_7;
      state_reg.mode_status <= MODE_STATUS_RESET;
      state_reg.onchip_ram_enable <= RAM_ENABLE_RESET;
      state_reg.address_enable_field <= ADDRESS_ENABLE_RESET;
      state_reg.direction <= DIRECTION_RESET;
      state_reg.bresp <= RESP_OKAY;
      state_reg.rresp <= RESP_OKAY;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign addr_out_en = state_reg.addr_out_en;
  assign port_out_en = state_reg.port_out_en;
  assign data_low_en = state_reg.data_low_en;
  assign data_high_en = state_reg.data_high_en;
  assign bus_ctrl_en = state_reg.bus_ctrl_en;
  assign rom_enable = state_reg.rom_enable;
  assign external_access_en = state_reg.external_access_en;
  assign ram_external_route = state_reg.ram_external_route;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic is5;
  logic is6;
  logic is7;
  assign is5 = state_reg.mode_ok && state_reg.mode == MODE_5;
  assign is6 = state_reg.mode_ok && state_reg.mode == MODE_6;
  assign is7 = state_reg.mode_ok && state_reg.mode == MODE_7;

  sequence s_read_mode;
    s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == MODE_CONTROL_ADDR;
  endsequence
  sequence s_mode_answer;
    ##1 s_axi_rvalid &&
      s_axi_rdata[2:0] == state_reg.mode_status;
  endsequence

  a_mode5_rom_off: assert property (
    is5 |=> !rom_enable && external_access_en && data_low_en)
    else $error("mode 5 rom or bus enables wrong");
  a_mode5_low_addr: assert property (
    is5 |=> addr_out_en[20:8] == 13'h1fff)
    else $error("mode 5 A20 to A8 not driven");
  a_mode5_upper_ae: assert property (
    is5 && state_reg.address_enable_field == 4'h0
      |=> addr_out_en[23:21] == 3'h0)
    else $error("mode 5 upper address on with field clear");
  a_port_out_dir: assert property (
    (is5 || is6) && !line_addr[20] && state_reg.direction[20]
      |=> port_out_en[20])
    else $error("disabled address pin not a port output");
  a_mode5_port_c: assert property (
    is5 |=> addr_out_en[7:0] == 8'hff && port_out_en[7:0] == 8'h00)
    else $error("mode 5 port C not address");
  a_bus_width: assert property (
    (is5 || is6) && area_16bit == 8'h00 |=> !data_high_en)
    else $error("bus 16 bits with no 16-bit area");
  a_mode6_reset_in: assert property (
    $rose(state_reg.mode_ok) && state_next.mode == MODE_6
      |=> ##1 addr_out_en == 24'h000000 && rom_enable)
    else $error("mode 6 pins not inputs after reset");
  a_mode6_port_c: assert property (
    is6 && !state_reg.direction[0] |=> !addr_out_en[0])
    else $error("mode 6 port C address without direction");
  a_mode7_single: assert property (
    is7 |=> !external_access_en && rom_enable && addr_out_en == 0)
    else $error("mode 7 external access or address open");
  a_mode_status: assert property (s_read_mode |-> s_mode_answer)
    else $error("mode status not latched on read");
  a_mode_held: assert property (
    state_reg.mode_ok |=> state_reg.mode_ok && $stable(state_reg.mode))
    else $error("operating mode changed after capture");
endmodule : pin_mode_select

// >>> test/bus_area_model.sv
// Bus controller stand-in that drives the per-area 16-bit flags
`timescale 1ns/1ps
module bus_area_model
  import pin_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] mode_select_pins,
  input wire logic load,
  input wire logic [7:0] area_in,
  output logic [7:0] area_16bit
);
  // The emulator area is never reached from this side
  // Reset width follows the strapped mode; later settings come from the bench
  always_ff @(posedge clk) begin
    if (rst)
      area_16bit <= (mode_select_pins == MODE4_CODE) ?
        8'hff : 8'h00;
    else if (load)
      area_16bit <= area_in;
  end
endmodule : bus_area_model

// >>> test/tb_top.sv
// Self-checking bench for the operating-mode pin function selector
`timescale 1ns/1ps
module tb_top;
  import pin_mode_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] pins = 3'h4;
  logic load = 1'b0;
  logic [7:0] area_req = 8'h00;
  logic [7:0] area;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] strb = 4'hf;
  int ram_on = 1;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [23:0] addr_en, port_en;
  logic d_lo, d_hi, ctrl, rom, ext, ram_ext;
  int errors = 0;
  int comparisons = 0;
  logic [15:0] lfsr = 16'h32bd;

  always #2.5 clk = ~clk;

  bus_area_model partner (.clk(clk), .rst(rst), .mode_select_pins(pins),
    .load(load), .area_in(area_req), .area_16bit(area));

  pin_mode_select #(.ROM_LESS(1'b1)) dut (
    .clk(clk),
    .rst(rst),
    .mode_select_pins(pins),
    .area_16bit(area),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .addr_out_en(addr_en),
    .port_out_en(port_en),
    .data_low_en(d_lo),
    .data_high_en(d_hi),
    .bus_ctrl_en(ctrl),
    .rom_enable(rom),
    .external_access_en(ext),
    .ram_external_route(ram_ext)
  );

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step

  task automatic conclude;
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Both channels offered together; each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (n == 40) begin
      errors++;
      conclude();
    end
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (n == 40) begin
      errors++;
      conclude();
    end
    rready <= 1'b0;
    check(rdata, ed);
    check(32'(rresp), 32'(er));
    @(posedge clk);
  endtask : rd

  // Reference model of every pin enable and the status word
  task automatic expect_all(input int code, input int ae, input int dir,
    input int ar);
    int m, mask, a, p, hi, ro, ex, rx;
    m = (code >= 4 && code <= 6) ? code : 7;
    mask = (ae == 0) ? 0 : ((((1 << (ae + 1)) - 1) << 8) & 'hffffff);
    case (m)
      4, 5: a = 'h1fffff | (mask & 'he00000);
      6: a = mask | (dir & 'hff);
      default: a = 0;
    endcase
    p = (m == 7) ? dir : (dir & ~a & 'hffff00);
    hi = (m != 7 && ar != 0) ? 1 : 0;
    ro = (m >= 6) ? 1 : 0;
    ex = (m != 7) ? 1 : 0;
    rx = (ram_on == 0 && m != 7) ? 1 : 0;
    check(32'(addr_en), a);
    check(32'(port_en), p);
    check(32'(d_lo), ex);
    check(32'(d_hi), hi);
    check(32'(ctrl), ex);
    check(32'(rom), ro);
    check(32'(ext), ex);
    check(32'(ram_ext), rx);
    rd(BUS_STATUS_ADDR, (1 << (m - 4)) | hi << 4 | ro << 5 | ex << 6 |
      rx << 7 | 'h100, RESP_OKAY);
  endtask : expect_all

  initial begin
    int codes[5] = '{4, 5, 6, 7, 1};
    int aes[6] = '{15, 12, 13, 14, 1, 0};
    int i, j, ae, dir, ar, nx;
    for (i = 0; i < 5; i++) begin
      pins <= 3'(codes[i]);
      rst <= 1'b1;
      ram_on = 1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      ar = (codes[i] == 4) ? 'hff : 0;
      expect_all(codes[i], 0, 0, ar);
      rd(MODE_CONTROL_ADDR, 'h80 | codes[i], RESP_OKAY);
      rd(SYSTEM_CONTROL_ADDR, 1, RESP_OKAY);
      for (j = 0; j < 6; j++) begin
        lfsr = step(lfsr);
        ae = (j < 5) ? aes[j] : int'(lfsr[3:0]);
        dir = int'(lfsr);
        ar = int'(lfsr[15:8]) & (j % 2 == 0 ? 'hff : 0);
        lfsr = step(lfsr);
        dir = (dir << 8 | int'(lfsr[7:0])) & 'hffffff;
        wr(PIN_FUNCTION_ADDR, ae, RESP_OKAY);
        wr(PORT_DIRECTION_ADDR, dir, RESP_OKAY);
        area_req <= 8'(ar);
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        repeat (2) @(posedge clk);
        expect_all(codes[i], ae, dir, ar);
      end
      // Unmapped places answer with an error and leave state alone
      rd(8'h14, 0, RESP_SLVERR);
      wr(8'h20, 32'hffffffff, RESP_SLVERR);
      wr(SYSTEM_CONTROL_ADDR, 0, RESP_OKAY);
      ram_on = 0;
      rd(SYSTEM_CONTROL_ADDR, 0, RESP_OKAY);
      // Only the middle direction byte is strobed in
      strb <= 4'h2;
      wr(PORT_DIRECTION_ADDR, 32'hffffffff, RESP_OKAY);
      strb <= 4'hf;
      dir = dir | 'hff00;
      rd(PORT_DIRECTION_ADDR, dir, RESP_OKAY);
      rd(PIN_FUNCTION_ADDR, ae, RESP_OKAY);
      // Pins move after capture: status follows, function stays
      nx = codes[(i + 1) % 5];
      pins <= 3'(nx);
      repeat (4) @(posedge clk);
      rd(MODE_CONTROL_ADDR, 'h80 | nx, RESP_OKAY);
      expect_all(codes[i], ae, dir, ar);
    end
    conclude();
  end
endmodule : tb_top
